// ==== logic/gssp_map.svh ====
// register map, field positions and timing counts of the serial port block
`ifndef GSSP_MAP_SVH
`define GSSP_MAP_SVH

`define GSSP_ADDR_W       8
`define GSSP_OFS_CTRL     8'h00
`define GSSP_OFS_TXWORD   8'h04
`define GSSP_OFS_STATUS   8'h08
`define GSSP_OFS_RXLAST   8'h0C

`define GSSP_RESP_OKAY    2'h0
`define GSSP_RESP_SLVERR  2'h2

`define GSSP_FRAME_BITS   5'h10
`define GSSP_LAST_BIT     5'h0F
`define GSSP_WORD_MSB     15
`define GSSP_BIT_WRITE    15
`define GSSP_BIT_CH_HIGH  13
`define GSSP_BIT_CH_LOW   12
`define GSSP_BIT_CODING   1
`define GSSP_CHAN_AUX1    2'h1
`define GSSP_CHAN_AUX2    2'h2
`define GSSP_CTRL_RST     16'h0000
`define GSSP_TXWORD_RST   16'h0000
`define GSSP_STAT_VIOL    0
`define GSSP_STAT_BUSY    1
`define GSSP_SYNC_IDLE    3'h7

`define GSSP_CLK_NS       8
`define GSSP_QUIET_NS     50
`define GSSP_QUIET_CYC    ((`GSSP_QUIET_NS + `GSSP_CLK_NS - 1) / `GSSP_CLK_NS)

`endif

// ==== logic/gssp_pkg.sv ====
// types of the serial port block
package gssp_pkg;
`include "gssp_map.svh"

    typedef enum logic [2:0] {
        GSSP_ST_IDLE  = 3'h1,
        GSSP_ST_SHIFT = 3'h2,
        GSSP_ST_DONE  = 3'h4
    } gssp_state_e;

    typedef struct packed {
        logic [`GSSP_ADDR_W-1:0] awaddr;
        logic                    awvalid;
        logic [31:0]             wdata;
        logic [3:0]              wstrb;
        logic                    wvalid;
        logic                    bready;
        logic [`GSSP_ADDR_W-1:0] araddr;
        logic                    arvalid;
        logic                    rready;
    } gssp_axi_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } gssp_axi_rsp_s;

    typedef struct packed {
        gssp_state_e   st;
        logic [2:0]    sel_p;
        logic [2:0]    clk_p;
        logic [1:0]    din_p;
        logic [4:0]    bit_cnt;
        logic [15:0]   rx_sh;
        logic [15:0]   tx_sh;
        logic          dout;
        logic          oe;
        logic          conv;
        logic [15:0]   ctrl;
        logic          aux_one;
        logic          aux_two;
        logic [15:0]   tx_word;
        logic [15:0]   rx_last;
        logic [15:0]   frames;
        logic [3:0]    quiet_cnt;
        logic          quiet_viol;
        gssp_axi_rsp_s rsp;
    } gssp_regs_s;
endpackage

// ==== logic/gssp_port.sv ====
// serial slave port of the yaw-rate sensor with its register slave
//
// How it works
// - a low select frames each transfer; its falling edge starts a conversion
// - input bit is sampled on each of the frame's first sixteen falling serial clock edges
// - output advances to its next bit after each of the frame's first sixteen falling serial clock edges
// - output driver turns on shortly after select goes low
// - output driver turns off after the frame's last falling edge
// - two channel bits in the input word pick auxiliary channel one or two
// - while select is high, output floats and clock and input are ignored
// - a frame is sixteen clocks, sixteen bits each way at once
// - first input bit one writes control settings; zero leaves them unchanged
// - control updates only after a full sixteen-clock frame
`timescale 1ns/1ns
`include "gssp_map.svh"

module gssp_port (
    // clock and reset
    input  wire logic                    CLK_SYS_IN,
    input  wire logic                    SRST_IN,
    // register bus
    input  wire gssp_pkg::gssp_axi_req_s AXI_REQ_IN,
    output      gssp_pkg::gssp_axi_rsp_s AXI_RSP_OUT,
    // serial pins
    input  wire logic                    SER_SEL_N_IN,
    input  wire logic                    SER_CLK_IN,
    input  wire logic                    SER_DIN_IN,
    output      logic                    SER_DOUT_OUT,
    output      logic                    SER_DOUT_OE_OUT,
    // converter side
    output      logic                    CONV_START_OUT,
    output      logic [15:0]             CTRL_WORD_OUT,
    output      logic                    CODING_TWOS_OUT,
    output      logic                    AUX_ANALOG_INPUT_ONE_SEL_OUT,
    output      logic                    AUX_ANALOG_INPUT_TWO_SEL_OUT
);
    import gssp_pkg::*;

    gssp_regs_s s_r;
    gssp_regs_s s_nxt;

    // channel bits to aux selection {two, one}
    function automatic logic [1:0] chan_dec(input logic [15:0] w);
        logic [1:0] code;
        code = {w[`GSSP_BIT_CH_HIGH], w[`GSSP_BIT_CH_LOW]};
        chan_dec = {code == `GSSP_CHAN_AUX2, code == `GSSP_CHAN_AUX1};
    endfunction

    // mapped register check
    function automatic logic addr_hit(input logic [`GSSP_ADDR_W-1:0] a);
        addr_hit = (a == `GSSP_OFS_CTRL) || (a == `GSSP_OFS_TXWORD) ||
                   (a == `GSSP_OFS_STATUS) || (a == `GSSP_OFS_RXLAST);
    endfunction

    // falling edge between second and third sync stage
    function automatic logic sync_fell(input logic [2:0] p);
        sync_fell = ~p[1] & p[2];
    endfunction

    always_comb begin
        logic        sel_low;
        logic        sel_fall;
        logic        clk_fall;
        logic [15:0] rx_new;
        logic [1:0]  aux;
        s_nxt    = s_r;
        s_nxt.conv = 1'b0;
        sel_low  = ~s_r.sel_p[1];
        sel_fall = sync_fell(s_r.sel_p);
        clk_fall = sync_fell(s_r.clk_p);
        rx_new   = {s_r.rx_sh[14:0], s_r.din_p[1]};
        aux      = chan_dec(rx_new);

        // pin synchronisers, third stage only for edge detection
        s_nxt.sel_p = {s_r.sel_p[1:0], SER_SEL_N_IN};
        s_nxt.clk_p = {s_r.clk_p[1:0], SER_CLK_IN};
        s_nxt.din_p = {s_r.din_p[0], SER_DIN_IN};

        // write channel
        if (s_r.rsp.bvalid && AXI_REQ_IN.bready) begin
            s_nxt.rsp.bvalid = 1'b0;
        end
        s_nxt.rsp.awready = 1'b0;
        s_nxt.rsp.wready  = 1'b0;
        if (AXI_REQ_IN.awvalid && AXI_REQ_IN.wvalid && !s_r.rsp.awready
            && !s_r.rsp.bvalid) begin
            s_nxt.rsp.awready = 1'b1;
            s_nxt.rsp.wready  = 1'b1;
        end
        if (s_r.rsp.awready) begin
            s_nxt.rsp.bvalid = 1'b1;
            s_nxt.rsp.bresp  = addr_hit(AXI_REQ_IN.awaddr) ? `GSSP_RESP_OKAY
                                                           : `GSSP_RESP_SLVERR;
            if (AXI_REQ_IN.awaddr == `GSSP_OFS_TXWORD) begin
                if (AXI_REQ_IN.wstrb[0]) begin
                    s_nxt.tx_word[7:0] = AXI_REQ_IN.wdata[7:0];
                end
                if (AXI_REQ_IN.wstrb[1]) begin
                    s_nxt.tx_word[15:8] = AXI_REQ_IN.wdata[15:8];
                end
            end
            if (AXI_REQ_IN.awaddr == `GSSP_OFS_STATUS && AXI_REQ_IN.wstrb[0]
                && AXI_REQ_IN.wdata[`GSSP_STAT_VIOL]) begin
                s_nxt.quiet_viol = 1'b0;
            end
        end

        // read channel
        if (s_r.rsp.rvalid && AXI_REQ_IN.rready) begin
            s_nxt.rsp.rvalid = 1'b0;
        end
        s_nxt.rsp.arready = 1'b0;
        if (AXI_REQ_IN.arvalid && !s_r.rsp.arready && !s_r.rsp.rvalid) begin
            s_nxt.rsp.arready = 1'b1;
        end
        if (s_r.rsp.arready) begin
            s_nxt.rsp.rvalid = 1'b1;
            s_nxt.rsp.rresp  = addr_hit(AXI_REQ_IN.araddr) ? `GSSP_RESP_OKAY
                                                           : `GSSP_RESP_SLVERR;
            case (AXI_REQ_IN.araddr)
                `GSSP_OFS_CTRL: begin
                    s_nxt.rsp.rdata = {16'h0000, s_r.ctrl};
                end
                `GSSP_OFS_TXWORD: begin
                    s_nxt.rsp.rdata = {16'h0000, s_r.tx_word};
                end
                `GSSP_OFS_STATUS: begin
                    s_nxt.rsp.rdata = {s_r.frames, 14'h0000, s_r.st != GSSP_ST_IDLE,
                                       s_r.quiet_viol};
                end
                `GSSP_OFS_RXLAST: begin
                    s_nxt.rsp.rdata = {16'h0000, s_r.rx_last};
                end
                default: begin
                    s_nxt.rsp.rdata = 32'h0000_0000;
                end
            endcase
        end

        // serial frame engine
        case (s_r.st)
            GSSP_ST_IDLE: begin
                s_nxt.oe      = 1'b0;
                s_nxt.bit_cnt = 5'h00;
                if (s_r.quiet_cnt != 4'(`GSSP_QUIET_CYC)) begin
                    s_nxt.quiet_cnt = s_r.quiet_cnt + 4'h1;
                end
                if (sel_fall) begin
                    s_nxt.conv  = 1'b1;
                    s_nxt.st    = GSSP_ST_SHIFT;
                    s_nxt.oe    = 1'b1;
                    s_nxt.tx_sh = s_r.tx_word;
                    s_nxt.dout  = s_r.tx_word[`GSSP_WORD_MSB];
                    s_nxt.quiet_cnt = 4'h0;
                    if (s_r.quiet_cnt != 4'(`GSSP_QUIET_CYC)) begin
                        s_nxt.quiet_viol = 1'b1;
                    end
                end
            end
            GSSP_ST_SHIFT: begin
                if (!sel_low) begin
                    s_nxt.st      = GSSP_ST_IDLE;
                    s_nxt.oe      = 1'b0;
                    s_nxt.bit_cnt = 5'h00;
                end else if (clk_fall) begin
                    s_nxt.rx_sh   = rx_new;
                    s_nxt.tx_sh   = {s_r.tx_sh[14:0], 1'b0};
                    s_nxt.dout    = s_r.tx_sh[`GSSP_WORD_MSB-1];
                    s_nxt.bit_cnt = s_r.bit_cnt + 5'h01;
                    if (s_r.bit_cnt == `GSSP_LAST_BIT) begin
                        s_nxt.st      = GSSP_ST_DONE;
                        s_nxt.oe      = 1'b0;
                        s_nxt.rx_last = rx_new;
                        s_nxt.frames  = s_r.frames + 16'h0001;
                        if (rx_new[`GSSP_BIT_WRITE]) begin
                            s_nxt.ctrl    = rx_new;
                            s_nxt.aux_one = aux[0];
                            s_nxt.aux_two = aux[1];
                        end
                    end
                end
            end
            GSSP_ST_DONE: begin
                s_nxt.oe = 1'b0;
                if (!sel_low) begin
                    s_nxt.st      = GSSP_ST_IDLE;
                    s_nxt.bit_cnt = 5'h00;
                end
            end
            default: begin
                s_nxt.st = GSSP_ST_IDLE;
                s_nxt.oe = 1'b0;
                s_nxt.bit_cnt = 5'h00;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (SRST_IN) begin
            s_r            <= '0;
            s_r.st         <= GSSP_ST_IDLE;
            s_r.sel_p      <= `GSSP_SYNC_IDLE;
            s_r.clk_p      <= `GSSP_SYNC_IDLE;
            s_r.ctrl       <= `GSSP_CTRL_RST;
            s_r.tx_word    <= `GSSP_TXWORD_RST;
            s_r.quiet_cnt  <= 4'(`GSSP_QUIET_CYC);
        end else begin
            s_r <= s_nxt;
        end
    end

    assign AXI_RSP_OUT                  = s_r.rsp;
    assign SER_DOUT_OUT                 = s_r.dout;
    assign SER_DOUT_OE_OUT              = s_r.oe;
    assign CONV_START_OUT               = s_r.conv;
    assign CTRL_WORD_OUT                = s_r.ctrl;
    assign CODING_TWOS_OUT              = s_r.ctrl[`GSSP_BIT_CODING];
    assign AUX_ANALOG_INPUT_ONE_SEL_OUT = s_r.aux_one;
    assign AUX_ANALOG_INPUT_TWO_SEL_OUT = s_r.aux_two;
endmodule

// ==== sim/gssp_port_monitor.sv ====
// checker of the serial pins and control outputs
`timescale 1ns/1ns
`include "gssp_map.svh"
module gssp_port_monitor (
    // clock and reset
    input wire logic        CLK_SYS_IN,
    input wire logic        SRST_IN,
    // serial pins
    input wire logic        SER_SEL_N_IN,
    input wire logic        SER_CLK_IN,
    input wire logic        SER_DOUT_OUT,
    input wire logic        SER_DOUT_OE_OUT,
    // converter side
    input wire logic        CONV_START_OUT,
    input wire logic [15:0] CTRL_WORD_OUT,
    input wire logic        CODING_TWOS_OUT,
    input wire logic        AUX_ANALOG_INPUT_ONE_SEL_OUT,
    input wire logic        AUX_ANALOG_INPUT_TWO_SEL_OUT
);
    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (SRST_IN);
    logic       sclk_q_r;
    logic [4:0] falls_r;
    // counts serial clock falls seen on the pin within a frame
    always_ff @(posedge CLK_SYS_IN) begin
        sclk_q_r <= SER_CLK_IN;
        if (SRST_IN || SER_SEL_N_IN) begin
            falls_r <= 5'h00;
        end else if (sclk_q_r && !SER_CLK_IN && falls_r != 5'h1F) begin
            falls_r <= falls_r + 5'h01;
        end
    end
    oe_off_last_a: assert property ($rose(falls_r == 5'h10) |-> ##[1:5] !SER_DOUT_OE_OUT)
        else $error("driver kept on after last clock fall");
    sequence sel_fall_s;
        $fell(SER_SEL_N_IN);
    endsequence
    sequence start_s;
        ##[1:5] (CONV_START_OUT && SER_DOUT_OE_OUT);
    endsequence
    start_on_select_a: assert property (sel_fall_s |-> start_s)
        else $error("no start after select fall");
    conv_one_pulse_a: assert property (CONV_START_OUT |=> !CONV_START_OUT)
        else $error("start pulse too long");
    conv_needs_select_a: assert property (CONV_START_OUT |-> $past(SER_SEL_N_IN, 2) == 1'b0)
        else $error("start without select");
    oe_release_a: assert property ($rose(SER_SEL_N_IN) |-> ##[1:6] !SER_DOUT_OE_OUT)
        else $error("driver kept on after select rise");
    dout_after_fall_a: assert property ($changed(SER_DOUT_OUT) && SER_DOUT_OE_OUT
        && $past(SER_DOUT_OE_OUT) |-> !$past(SER_CLK_IN, 2) || !$past(SER_CLK_IN, 3)
        || !$past(SER_CLK_IN, 4) || !$past(SER_CLK_IN, 5))
        else $error("output moved without a clock fall");
    ctrl_at_end_a: assert property ($changed(CTRL_WORD_OUT)
        |-> !SER_DOUT_OE_OUT && !SER_SEL_N_IN)
        else $error("control changed outside frame end");
    aux_code_a: assert property (AUX_ANALOG_INPUT_ONE_SEL_OUT == (CTRL_WORD_OUT[13:12] ==
        `GSSP_CHAN_AUX1) && AUX_ANALOG_INPUT_TWO_SEL_OUT == (CTRL_WORD_OUT[13:12] ==
        `GSSP_CHAN_AUX2))
        else $error("aux select mismatch");
    coding_bit_a: assert property (CODING_TWOS_OUT == CTRL_WORD_OUT[1])
        else $error("coding bit mismatch");
endmodule
bind gssp_port gssp_port_monitor u_mon (.CLK_SYS_IN(CLK_SYS_IN), .SRST_IN(SRST_IN),
    .SER_SEL_N_IN(SER_SEL_N_IN), .SER_CLK_IN(SER_CLK_IN), .SER_DOUT_OUT(SER_DOUT_OUT),
    .SER_DOUT_OE_OUT(SER_DOUT_OE_OUT), .CONV_START_OUT(CONV_START_OUT),
    .CTRL_WORD_OUT(CTRL_WORD_OUT), .CODING_TWOS_OUT(CODING_TWOS_OUT),
    .AUX_ANALOG_INPUT_ONE_SEL_OUT(AUX_ANALOG_INPUT_ONE_SEL_OUT),
    .AUX_ANALOG_INPUT_TWO_SEL_OUT(AUX_ANALOG_INPUT_TWO_SEL_OUT));

// ==== sim/gssp_host.sv ====
// host master model driving the serial pins
`timescale 1ns/1ns
module gssp_host (
    // clock
    input  wire logic clk_in,
    // serial pins
    input  wire logic dout_in,
    input  wire logic oe_in,
    output      logic sel_n_out,
    output      logic sclk_out,
    output      logic din_out
);
    wire line = oe_in ? dout_in : ~dout_in;
    initial begin
        sel_n_out = 1'b1;
        sclk_out = 1'b1;
        din_out = 1'b0;
    end
    task automatic frame(input logic [15:0] w, input int n, input int gap, input logic en,
                         output logic [15:0] rx);
        rx = '0;
        @(posedge clk_in);
        sel_n_out <= ~en;
        for (int i = 0; i < n; i++) begin
            din_out <= w[15-i];
            repeat (4) @(posedge clk_in);
            rx = {rx[14:0], line};
            sclk_out <= 1'b0;
            repeat (4) @(posedge clk_in);
            sclk_out <= 1'b1;
        end
        repeat (4) @(posedge clk_in);
        sel_n_out <= 1'b1;
        repeat (gap) @(posedge clk_in);
    endtask
endmodule

// ==== sim/gssp_port_tb.sv ====
// self-checking bench of the serial port block
`timescale 1ns/1ns
`include "gssp_map.svh"
module gssp_port_tb;
    import gssp_pkg::*;
    logic          clk = 1'b0;
    logic          srst = 1'b1;
    gssp_axi_req_s req = '0;
    gssp_axi_rsp_s rsp;
    wire           sel_n, sclk, din, dout, oe, conv, coding, aux1, aux2;
    wire [15:0]    ctrl;
    int            errors = 0;
    int            checked = 0;
    logic [31:0]   rd;
    logic [15:0]   rx;
    logic [1:0]    resp;
    always #4 clk = ~clk;
    gssp_port uut (.CLK_SYS_IN(clk), .SRST_IN(srst), .AXI_REQ_IN(req), .AXI_RSP_OUT(rsp),
        .SER_SEL_N_IN(sel_n), .SER_CLK_IN(sclk), .SER_DIN_IN(din), .SER_DOUT_OUT(dout),
        .SER_DOUT_OE_OUT(oe), .CONV_START_OUT(conv), .CTRL_WORD_OUT(ctrl),
        .CODING_TWOS_OUT(coding), .AUX_ANALOG_INPUT_ONE_SEL_OUT(aux1),
        .AUX_ANALOG_INPUT_TWO_SEL_OUT(aux2));
    gssp_host host (.clk_in(clk), .dout_in(dout), .oe_in(oe), .sel_n_out(sel_n),
        .sclk_out(sclk), .din_out(din));
    task automatic wrap_up;
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [3:0] s = 4'hF);
        int n;
        n = 0;
        @(posedge clk);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= s;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1 && n < 40);
        resp = rsp.bresp;
        req.bready <= 1'b0;
        if (n >= 40) begin
            errors++;
            wrap_up();
        end
    endtask
    task automatic axi_rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge clk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1 && n < 40);
        rd = rsp.rdata;
        resp = rsp.rresp;
        req.rready <= 1'b0;
        if (n >= 40) begin
            errors++;
            wrap_up();
        end
    endtask
    task automatic t_regs;
        axi_rd(`GSSP_OFS_CTRL);
        chk("ctrl reset", 32'h0, rd);
        axi_rd(`GSSP_OFS_TXWORD);
        chk("txword reset", 32'h0, rd);
        axi_rd(8'h10);
        chk("unmapped resp", {30'h0, `GSSP_RESP_SLVERR}, {30'h0, resp});
        chk("unmapped data", 32'h0, rd);
        axi_wr(`GSSP_OFS_TXWORD, 32'hFFFF1234);
        chk("txword wr resp", {30'h0, `GSSP_RESP_OKAY}, {30'h0, resp});
        axi_rd(`GSSP_OFS_TXWORD);
        chk("txword readback", 32'h00001234, rd);
        axi_wr(`GSSP_OFS_TXWORD, 32'h0000ABCD, 4'h2);
        axi_rd(`GSSP_OFS_TXWORD);
        chk("txword strobe", 32'h0000AB34, rd);
        axi_wr(`GSSP_OFS_CTRL, 32'h0000FFFF);
        axi_rd(`GSSP_OFS_CTRL);
        chk("ctrl read only", 32'h0, rd);
        axi_wr(8'h10, 32'h1);
        chk("unmapped wr resp", {30'h0, `GSSP_RESP_SLVERR}, {30'h0, resp});
    endtask
    task automatic t_config;
        logic [15:0] w [4] = '{16'h9002, 16'hA000, 16'hB000, 16'h8000};
        for (int i = 0; i < 4; i++) begin
            axi_wr(`GSSP_OFS_TXWORD, 32'h0000C3A5 + i);
            host.frame(w[i], 16, 10, 1'b1, rx);
            chk("rx word", 32'h0000C3A5 + i, {16'h0, rx});
            chk("ctrl", {16'h0, w[i]}, {16'h0, ctrl});
            chk("aux", {30'h0, w[i][13:12] == 2'h2, w[i][13:12] == 2'h1}, {30'h0, aux2, aux1});
            chk("coding", {31'h0, w[i][1]}, {31'h0, coding});
        end
        axi_rd(`GSSP_OFS_RXLAST);
        chk("rxlast", 32'h00008000, rd);
        axi_rd(`GSSP_OFS_STATUS);
        chk("frames", 32'h4, {16'h0, rd[31:16]});
        chk("busy idle", 32'h0, {31'h0, rd[`GSSP_STAT_BUSY]});
    endtask
    task automatic t_nochange;
        host.frame(16'h2000, 16, 10, 1'b1, rx);
        chk("read frame ctrl", 32'h8000, {16'h0, ctrl});
        host.frame(16'h9000, 10, 10, 1'b1, rx);
        chk("short frame ctrl", 32'h8000, {16'h0, ctrl});
        host.frame(16'hA000, 16, 10, 1'b0, rx);
        chk("idle ctrl", 32'h8000, {16'h0, ctrl});
        axi_wr(`GSSP_OFS_TXWORD, 32'h5A3C);
        host.frame(16'h0000, 16, 10, 1'b1, rx);
        chk("rx after abort", 32'h5A3C, {16'h0, rx});
    endtask
    task automatic t_quiet;
        host.frame(16'h0000, 16, 2, 1'b1, rx);
        host.frame(16'h0000, 16, 10, 1'b1, rx);
        axi_rd(`GSSP_OFS_STATUS);
        chk("quiet flag", 32'h1, {31'h0, rd[0]});
        axi_wr(`GSSP_OFS_STATUS, 32'h1);
        axi_rd(`GSSP_OFS_STATUS);
        chk("quiet cleared", 32'h0, {31'h0, rd[0]});
    endtask
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        t_regs();
        t_config();
        t_nochange();
        t_quiet();
        wrap_up();
    end
endmodule
